// [verilog/sfw_reg_write_ctrl.sv]
// register write command handling of a serial flash, core clock side
`timescale 1ns/1ps
`include "sfw_defines.svh"
module sfw_reg_write_ctrl #(
   parameter int NV_CYCLES = `SFW_NV_CYCLES
) (
   input  wire logic       I_CORE_CLK,
   input  wire logic       I_RESET_N,
   input  wire logic       I_SCK,
   input  wire logic       I_CS_N,
   input  wire logic       I_SI,
   input  wire logic       I_WP_N,
   input  wire logic       I_PROG_FAULT,
   input  wire logic       I_ERASE_FAULT,
   output logic [7:0]      O_STATUS1,
   output logic [7:0]      O_CONFIG,
   output logic [7:0]      O_STATUS2,
   output logic [7:0]      O_BANK_ADDR,
   output logic            O_BANK_OPEN
);
   import sfw_pkg::*;

   // a volatile-only write still shows one full core cycle of busy
   localparam int VOL_CYCLES = (`SFW_VOL_CYCLES < 1) ? 1 : `SFW_VOL_CYCLES;

   // merge written data into a register: only writable bits follow the data,
   // and one-time bits that are already set stay set whatever is written
   function automatic logic [7:0] merge_bits(input logic [7:0] old_val,
                                             input logic [7:0] new_val,
                                             input logic [7:0] wmask,
                                             input logic [7:0] otp);
      merge_bits = ((old_val & ~wmask) | (new_val & wmask)) | (old_val & otp);
   endfunction

   // true when a merged value changes any non-volatile bit
   function automatic logic nv_touched(input logic [7:0] old_val,
                                       input logic [7:0] new_val,
                                       input logic [7:0] nvmask);
      nv_touched = |((old_val ^ new_val) & nvmask);
   endfunction

   // ---------------------------------------------------------------
   // link side capture
   // ---------------------------------------------------------------
   sfw_frame_t frame;     // quasi-static once chip select is high

   sfw_frame_capture u_capture (
      .i_sck   (I_SCK),
      .i_cs_n  (I_CS_N),
      .i_si    (I_SI),
      .o_frame (frame)
   );

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic cs_meta;          // first stage, read only by cs_sync
   logic cs_sync;          // chip select in core domain
   logic cs_last;          // previous value for edge detect
   logic tog_meta;         // first stage of the frame activity flag
   logic tog_sync;         // frame activity flag in core domain
   logic tog_seen;         // serial edges seen in the current frame
   logic wp_meta;          // first stage of the protect pin
   logic wp_sync;          // protect pin in core domain

   // chip select and protect pin come from the host: two flops each
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_last <= 1'b1;
         wp_meta <= 1'b1;
         wp_sync <= 1'b1;
      end else begin
         cs_meta <= I_CS_N;
         cs_sync <= cs_meta;
         cs_last <= cs_sync;
         wp_meta <= I_WP_N;
         wp_sync <= wp_meta;
      end
   end

   // the activity flag rises at the first serial edge, at least three core
   // cycles before chip select rises, and is caught in tog_seen so that its
   // fall together with chip select cannot race the edge detect
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         tog_meta <= 1'b0;
         tog_sync <= 1'b0;
      end else begin
         tog_meta <= frame.active;
         tog_sync <= tog_meta;
      end
   end

   // ---------------------------------------------------------------
   // frame decode
   // ---------------------------------------------------------------
   logic [7:0]  sr1;       // status register 1, output directly
   logic [7:0]  cr;        // configuration register
   logic [7:0]  sr2;       // status register 2
   logic [7:0]  bar;       // bank address register
   logic        bank_open; // next write goes to the bank register
   sfw_state_t  state;     // write sequencer state
   sfw_state_t  next_state;
   logic [`SFW_TIMER_W-1:0] timer;  // cycles left in the self-timed write
   logic [7:0]  pend_sr1;  // values applied at completion
   logic [7:0]  pend_cr;
   logic [7:0]  pend_sr2;

   // cs rising edge; the serial clock has stopped so the frame is stable
   wire frame_end   = cs_sync & ~cs_last;
   // a select pulse with no serial edges must not replay the last frame
   wire frame_bits  = tog_seen;
   wire frame_done  = frame_end & frame_bits;

   wire op_wrr      = frame.opcode == `SFW_OP_WRITE_REGS;
   wire op_write_enable_cmd     = frame.opcode == `SFW_OP_WRITE_EN;
   wire op_wrdi     = frame.opcode == `SFW_OP_WRITE_DIS;
   wire op_clsr     = frame.opcode == `SFW_OP_CLEAR_STATUS;
   wire op_prefix   = frame.opcode == `SFW_OP_BANK_PREFIX;
   wire len_opcode  = frame.count == `SFW_LEN_OPCODE;
   wire len_one     = frame.count == `SFW_LEN_ONE_BYTE;
   wire len_two     = frame.count == `SFW_LEN_TWO_BYTES;
   wire len_three   = frame.count == `SFW_LEN_THREE_BYTES;

   wire len_ok      = len_one | len_two | len_three;

   wire write_in_progress         = sr1[`SFW_SR1_WIP];
   wire write_enable_latch         = sr1[`SFW_SR1_WEL];

   wire hw_protect  = sr1[`SFW_SR1_SWD] & ~wp_sync;

   // one-byte commands need chip select high right after the opcode
   wire cmd_write_enable_cmd    = frame_done & op_write_enable_cmd & len_opcode & ~write_in_progress;
   wire cmd_wrdi    = frame_done & op_wrdi & len_opcode & ~write_in_progress;
   wire cmd_clsr    = frame_done & op_clsr & len_opcode;
   wire cmd_prefix  = frame_done & op_prefix & len_opcode;

   wire bank_write  = frame_done & op_wrr & bank_open & len_ok;

   // pin only matters with disable bit
   wire regs_write  = frame_done & op_wrr & ~bank_open & len_ok & write_enable_latch & ~write_in_progress
                      & ~hw_protect & (state == SFW_ST_IDLE);

   wire [7:0] new_sr1 = merge_bits(sr1, frame.data[23:16], `SFW_SR1_WMASK,
                                   `SFW_SR1_OTP);
   wire [7:0] new_cr  = (len_two | len_three)
                        ? merge_bits(cr, frame.data[15:8], `SFW_CR_WMASK, `SFW_CR_OTP)
                        : cr;
   wire [7:0] new_sr2 = len_three
                        ? merge_bits(sr2, frame.data[7:0], `SFW_SR2_WMASK, `SFW_SR2_OTP)
                        : sr2;

   wire nv_write    = nv_touched(sr1, new_sr1, `SFW_SR1_NV)
                    | nv_touched(cr, new_cr, `SFW_CR_NV)
                    | nv_touched(sr2, new_sr2, `SFW_SR2_NV);
   wire [`SFW_TIMER_W-1:0] start_count = nv_write
                                         ? `SFW_TIMER_W'(NV_CYCLES - 1)
                                         : `SFW_TIMER_W'(VOL_CYCLES - 1);

   wire timer_zero  = timer == '0;
   wire write_end   = (state == SFW_ST_WRITE) & timer_zero;
   wire write_fault = write_end & (I_PROG_FAULT | I_ERASE_FAULT);
   wire write_ok    = write_end & ~write_fault;

   // ---------------------------------------------------------------
   // sequencer next state
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         // wait for an accepted register write
         SFW_ST_IDLE: begin
            if (regs_write) begin
               next_state = SFW_ST_WRITE;
            end
         end
         // self-timed write in progress
         SFW_ST_WRITE: begin
            if (write_fault) begin
               next_state = SFW_ST_FAULT;
            end else if (write_ok) begin
               next_state = SFW_ST_IDLE;
            end
         end
         // stays busy until the error flags are cleared
         SFW_ST_FAULT: begin
            if (cmd_clsr) begin
               next_state = SFW_ST_IDLE;
            end
         end
         default: begin
            next_state = SFW_ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // status register 1 next value, one field at a time
   // ---------------------------------------------------------------
   wire next_wip  = (regs_write | (write_in_progress & ~write_ok & ~(cmd_clsr & state == SFW_ST_FAULT)));

   // cleared at completion, good or bad
   wire next_wel  = write_end ? 1'b0 :
                    cmd_write_enable_cmd  ? 1'b1 :
                    cmd_wrdi  ? 1'b0 : write_enable_latch;

   // fault flags set by failed write
   // a fault at completion wins over a clear in the same cycle
   wire next_pfail = (write_end & I_PROG_FAULT)
                   | (sr1[`SFW_SR1_PFAIL] & ~cmd_clsr);
   wire next_efail = (write_end & I_ERASE_FAULT)
                   | (sr1[`SFW_SR1_EFAIL] & ~cmd_clsr);

   // data fields only change when a good write completes
   wire [7:0] data_sr1 = write_ok ? pend_sr1 : sr1;

   wire [7:0] next_sr1 = {data_sr1[`SFW_SR1_SWD], next_pfail, next_efail,
                          data_sr1[`SFW_SR1_BP_HI:`SFW_SR1_BP_LO], next_wel, next_wip};

   // extended bit and the rest kept
   wire [7:0] next_bar = bank_write
                         ? ((bar & ~`SFW_BAR_LOW_MASK) | (frame.data[23:16] & `SFW_BAR_LOW_MASK))
                         : bar;

   wire next_bank_open = frame_end ? cmd_prefix : bank_open;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------

   // sequencer state and frame bookkeeping
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         state     <= SFW_ST_IDLE;
         tog_seen  <= 1'b0;
         bank_open <= 1'b0;
      end else begin
         state     <= next_state;
         bank_open <= next_bank_open;
         // clear at frame end wins; the activity flag may lag chip select by
         // a cycle, so it only sets while the synchronised select is low
         if (frame_end) begin
            tog_seen <= 1'b0;
         end else if (tog_sync && !cs_sync) begin
            tog_seen <= 1'b1;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         timer <= '0;
      end else if (regs_write) begin
         timer <= start_count;
      end else if (!timer_zero) begin
         timer <= timer - `SFW_TIMER_W'(1);
      end
   end

   // pending values are caught at acceptance; the host may start a new frame
   // while the write runs, so the live frame cannot be used at completion
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         pend_sr1 <= `SFW_SR1_RESET;
         pend_cr  <= `SFW_CR_RESET;
         pend_sr2 <= `SFW_SR2_RESET;
      end else if (regs_write) begin
         pend_sr1 <= new_sr1;
         pend_cr  <= new_cr;
         pend_sr2 <= new_sr2;
      end
   end

   // visible registers; reset values stand for the non-volatile copy
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         sr1 <= `SFW_SR1_RESET;
         cr  <= `SFW_CR_RESET;
         sr2 <= `SFW_SR2_RESET;
         bar <= `SFW_BAR_RESET;
      end else begin
         sr1 <= next_sr1;
         bar <= next_bar;
         if (write_ok) begin
            cr  <= pend_cr;
            sr2 <= pend_sr2;
         end
      end
   end

   // outputs come straight from the flops above
   assign O_STATUS1   = sr1;
   assign O_CONFIG    = cr;
   assign O_STATUS2   = sr2;
   assign O_BANK_ADDR = bar;
   assign O_BANK_OPEN = bank_open;

endmodule

// [shared/sfw_defines.svh]
// constants for the serial flash register write control block
`ifndef SFW_DEFINES_SVH
`define SFW_DEFINES_SVH

// command opcodes
`define SFW_OP_WRITE_REGS   8'h01
`define SFW_OP_WRITE_EN     8'h06
`define SFW_OP_WRITE_DIS    8'h04
`define SFW_OP_CLEAR_STATUS 8'h30
`define SFW_OP_BANK_PREFIX  8'hB9

// status register 1 field positions
`define SFW_SR1_WIP         0
`define SFW_SR1_WEL         1
`define SFW_SR1_BP_LO       2
`define SFW_SR1_BP_HI       4
`define SFW_SR1_EFAIL       5
`define SFW_SR1_PFAIL       6
`define SFW_SR1_SWD         7

// configuration and bank register field positions
`define SFW_CR_QUAD         1
`define SFW_BAR_EXT         7
`define SFW_BAR_LOW_MASK    8'h03

// write masks, one-time-programmable masks and non-volatile masks
`define SFW_SR1_WMASK       8'h9C
`define SFW_SR1_OTP         8'h00
`define SFW_SR1_NV          8'h9C
`define SFW_CR_WMASK        8'hFE
`define SFW_CR_OTP          8'h3C
`define SFW_CR_NV           8'h3E
`define SFW_SR2_WMASK       8'h60
`define SFW_SR2_OTP         8'h00
`define SFW_SR2_NV          8'h00

// reset values
`define SFW_SR1_RESET       8'h00
`define SFW_CR_RESET        8'h00
`define SFW_SR2_RESET       8'h00
`define SFW_BAR_RESET       8'h00

// frame lengths in serial bits, opcode included
`define SFW_LEN_OPCODE      6'h08
`define SFW_LEN_ONE_BYTE    6'h10
`define SFW_LEN_TWO_BYTES   6'h18
`define SFW_LEN_THREE_BYTES 6'h20

// timing
`define SFW_CORE_MHZ        25
`define SFW_T_CS_NS         50
`define SFW_T_W_NS          200000
`define SFW_VOL_CYCLES      ((`SFW_T_CS_NS * `SFW_CORE_MHZ) / 1000)
`define SFW_NV_CYCLES       ((`SFW_T_W_NS * `SFW_CORE_MHZ) / 1000)
`define SFW_TIMER_W         23

`endif

// [shared/sfw_pkg.sv]
// types shared by the serial flash register write control block
package sfw_pkg;

   // one finished serial frame as seen by the core side
   typedef struct packed {
      logic        active;   // high from the first serial edge until chip select rises
      logic [5:0]  count;    // serial bits received, saturating
      logic [7:0]  opcode;   // first byte of the frame
      logic [23:0] data;     // data bytes, first byte in the top lane
   } sfw_frame_t;

   // self-timed write sequencer states
   typedef enum logic [1:0] {
      SFW_ST_IDLE,
      SFW_ST_WRITE,
      SFW_ST_FAULT
   } sfw_state_t;

endpackage

// [verilog/sfw_frame_capture.sv]
// serial clock side capture of one command frame
`timescale 1ns/1ps
`include "sfw_defines.svh"
module sfw_frame_capture (
   input  wire logic             i_sck,
   input  wire logic             i_cs_n,
   input  wire logic             i_si,
   output sfw_pkg::sfw_frame_t   o_frame
);
   import sfw_pkg::*;

   logic       armed;     // set while chip select is high, cleared by first edge
   logic [5:0] count;     // bits of the current frame
   logic [7:0] opcode;    // opcode shift register
   logic [23:0] data;     // data byte lanes

   // position of the incoming data bit; first data bit lands in bit 23
   wire  [5:0] data_pos  = 6'h1F - count;
   wire        in_opcode = count < `SFW_LEN_OPCODE;
   wire        in_data   = !in_opcode && (count < `SFW_LEN_THREE_BYTES);

   // the serial clock stops between frames, so frame start is flagged by
   // chip select itself; this flop is only ever preset to a constant
   always_ff @(posedge i_sck or posedge i_cs_n) begin
      if (i_cs_n) begin
         armed <= 1'b1;
      end else begin
         armed <= 1'b0;
      end
   end

   // bit counter restarts at one on the first edge and saturates at the top value 6'h3F
   always_ff @(posedge i_sck) begin
      if (armed) begin
         count <= 6'h01;
      end else if (count != 6'h3F) begin
         count <= count + 6'h01;
      end
   end

   // opcode shifts in msb first during the first eight bits
   always_ff @(posedge i_sck) begin
      if (armed) begin
         opcode <= {7'h00, i_si};
      end else if (in_opcode) begin
         opcode <= {opcode[6:0], i_si};
      end
   end

   // data bits go to fixed lanes; a fourth byte and beyond is dropped
   always_ff @(posedge i_sck) begin
      if (!armed && in_data) begin
         data[data_pos[4:0]] <= i_si;
      end
   end

   // held still once the serial clock stops, read by the core after cs rises
   // activity is the inverse of the start flag, so it starts known and needs no reset
   assign o_frame = '{active: ~armed, count: count, opcode: opcode, data: data};

endmodule

// [test/sfw_host_model.sv]
// host side serial controller model that sends one frame per request
`timescale 1ns/1ps
module sfw_host_model (
   input  wire logic        i_go,
   input  wire logic [5:0]  i_nbits,
   input  wire logic [31:0] i_bits,
   output logic             o_sck,
   output logic             o_cs_n,
   output logic             o_si,
   output logic             o_busy
);
   // frame engine: serial clock stands low outside frames
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b0;
      o_si = 1'b0;
      o_busy = 1'b0;
      // a real select rise before any clock edge presets the frame start flag
      #1 o_cs_n = 1'b1;
      forever begin
         wait (i_go === 1'b1);
         o_busy = 1'b1;
         #17;
         o_cs_n = 1'b0;
         // caller supplies zeroed reserved bits, long formats
         for (int n = 0; n < i_nbits; n++) begin
            o_si = i_bits[31 - n];
            #20 o_sck = 1'b1;
            #40 o_sck = 1'b0;
            #20;
         end
         // a select pulse without serial edges must still span core cycles
         if (i_nbits == 6'h00) begin
            #100;
         end
         // select rises right after the last counted bit
         #20 o_cs_n = 1'b1;
         // released data line must not look like held data
         o_si = ~o_si;
         // select high time well above the 160 ns minimum
         #200 o_busy = 1'b0;
         wait (i_go === 1'b0);
      end
   end
endmodule

// [test/sfw_checker.sv]
// concurrent checks on the register write control ports
`timescale 1ns/1ps
`include "sfw_defines.svh"
module sfw_checker #(
   parameter int NV_CYCLES = 20
) (
   input wire logic       I_CORE_CLK,
   input wire logic       I_RESET_N,
   input wire logic       I_SCK,
   input wire logic       I_CS_N,
   input wire logic       I_SI,
   input wire logic       I_WP_N,
   input wire logic       I_PROG_FAULT,
   input wire logic       I_ERASE_FAULT,
   input wire logic [7:0] O_STATUS1,
   input wire logic [7:0] O_CONFIG,
   input wire logic [7:0] O_STATUS2,
   input wire logic [7:0] O_BANK_ADDR,
   input wire logic       O_BANK_OPEN
);
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESET_N);
   int busy_cnt;  // cycles busy without a fault flag
   // busy length counter, cleared when idle or faulted
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N || !O_STATUS1[0] || O_STATUS1[6:5] != 2'h0) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= busy_cnt + 1;
      end
   end
   property p_ext_keep; O_BANK_ADDR[7:2] == 6'h00; endproperty
   property p_bank_when; $changed(O_BANK_ADDR) |-> $fell(O_BANK_OPEN); endproperty
   property p_bank_nobusy; $fell(O_BANK_OPEN) |-> !$rose(O_STATUS1[0]); endproperty
   property p_busy_wel; $rose(O_STATUS1[0]) |-> O_STATUS1[1]; endproperty
   property p_done_wel; $fell(O_STATUS1[0]) |-> !O_STATUS1[1]; endproperty
   property p_cfg_done;
      $changed(O_CONFIG) || $changed(O_STATUS2) |-> $fell(O_STATUS1[0]);
   endproperty
   property p_otp; ($past(O_CONFIG) & `SFW_CR_OTP & ~O_CONFIG) == 8'h00; endproperty
   property p_nv_time; busy_cnt <= NV_CYCLES + 1; endproperty
   // protection held for a few cycles means no write may start
   property p_lock;
      (!I_WP_N && O_STATUS1[7] && !O_STATUS1[0]) [*5] |=> !$rose(O_STATUS1[0]);
   endproperty
   property p_fault; $rose(O_STATUS1[6]) |-> $past(I_PROG_FAULT) && O_STATUS1[0]; endproperty
   a_ext_keep: assert property (p_ext_keep) else $error("bank upper bits moved");
   a_bank_when: assert property (p_bank_when) else $error("bank change outside window");
   a_bank_nobusy: assert property (p_bank_nobusy) else $error("bank write went busy");
   a_busy_wel: assert property (p_busy_wel) else $error("write began without latch");
   a_done_wel: assert property (p_done_wel) else $error("latch kept after write");
   a_cfg_done: assert property (p_cfg_done) else $error("register moved off completion");
   a_otp: assert property (p_otp) else $error("one-time bit cleared");
   a_nv_time: assert property (p_nv_time) else $error("write took too long");
   a_lock: assert property (p_lock) else $error("write began while locked");
   a_fault: assert property (p_fault) else $error("program flag without fault");
   c_bank: cover property ($fell(O_BANK_OPEN) && $changed(O_BANK_ADDR));
   c_done: cover property ($fell(O_STATUS1[0]));
   c_fault: cover property ($rose(O_STATUS1[6]));
endmodule
bind sfw_reg_write_ctrl sfw_checker #(.NV_CYCLES(NV_CYCLES)) sfw_checker_i (
   .I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N), .I_SCK(I_SCK), .I_CS_N(I_CS_N),
   .I_SI(I_SI), .I_WP_N(I_WP_N), .I_PROG_FAULT(I_PROG_FAULT),
   .I_ERASE_FAULT(I_ERASE_FAULT), .O_STATUS1(O_STATUS1), .O_CONFIG(O_CONFIG),
   .O_STATUS2(O_STATUS2), .O_BANK_ADDR(O_BANK_ADDR), .O_BANK_OPEN(O_BANK_OPEN)
);

// [test/spi_flash_register_write_control_tb.sv]
// self-checking bench for the register write control block
`timescale 1ns/1ps
`include "sfw_defines.svh"
module spi_flash_register_write_control_tb;
   localparam int nv = 20;  // shortened long write time
   // {pin level, data byte, expected status 1}
   localparam logic [16:0] prot_tab [5] = '{17'h00082, 17'h10000, 17'h09C9C,
                                            17'h0009E, 17'h10000};
   logic        core_clk;     // 40 ns core clock
   logic        reset_n;      // synchronous reset
   logic        wp_n;         // write-protect pin
   logic        prog_fault;   // injected program failure
   logic        erase_fault;  // injected erase failure
   logic        go;           // frame request to the host model
   logic [5:0]  nbits;        // serial bits in the frame
   logic [31:0] bits;         // frame bits, msb first
   logic        sck;          // serial clock from the host
   logic        cs_n;         // chip select
   logic        si;           // serial data
   logic        host_busy;    // host model frame in flight
   logic [7:0]  status1;      // status register 1
   logic [7:0]  cfg;          // configuration register
   logic [7:0]  status2;      // status register 2
   logic [7:0]  bank_addr;    // bank address register
   logic        bank_open;    // bank window open
   int          num_errors;   // mismatches
   int          checks_done;  // comparisons
   sfw_host_model sfw_host_model_i (.i_go(go), .i_nbits(nbits), .i_bits(bits),
      .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_busy(host_busy));
   sfw_reg_write_ctrl #(.NV_CYCLES(nv)) sfw_reg_write_ctrl_i (.I_CORE_CLK(core_clk),
      .I_RESET_N(reset_n), .I_SCK(sck), .I_CS_N(cs_n), .I_SI(si), .I_WP_N(wp_n),
      .I_PROG_FAULT(prog_fault), .I_ERASE_FAULT(erase_fault), .O_STATUS1(status1),
      .O_CONFIG(cfg), .O_STATUS2(status2), .O_BANK_ADDR(bank_addr),
      .O_BANK_OPEN(bank_open));
   // core clock
   initial core_clk = 1'b0;
   always #20 core_clk = ~core_clk;
   // compare one value and count it
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic finish_test;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // one frame through the host model; the count guards against a hang
   task automatic frame(input logic [5:0] n, input logic [31:0] b);
      int t;
      t = 0;
      @(negedge core_clk);
      nbits = n;
      bits = b;
      go = 1'b1;
      while (host_busy !== 1'b1 && t < 200) begin
         @(negedge core_clk);
         t++;
      end
      go = 1'b0;
      while (host_busy !== 1'b0 && t < 200) begin
         @(negedge core_clk);
         t++;
      end
      if (t >= 200) begin
         num_errors++;
         finish_test();
      end
      repeat (6) @(negedge core_clk);
   endtask
   // optional latch set, register write, then wait out the long write
   task automatic wr(input logic write_enable_cmd, input logic [5:0] n, input logic [23:0] d);
      if (write_enable_cmd) begin
         frame(6'h08, {`SFW_OP_WRITE_EN, 24'h000000});
      end
      frame(n, {`SFW_OP_WRITE_REGS, d});
      repeat (nv + 4) @(negedge core_clk);
   endtask
   // main sequence
   initial begin
      reset_n = 1'b0;
      wp_n = 1'b1;
      prog_fault = 1'b0;
      erase_fault = 1'b0;
      go = 1'b0;
      nbits = 6'h00;
      bits = 32'h00000000;
      num_errors = 0;
      checks_done = 0;
      repeat (6) @(negedge core_clk);
      reset_n = 1'b1;
      @(negedge core_clk);
      check(status1 | cfg | status2 | bank_addr, 8'h00, "reset");
      wr(1'b0, 6'h10, 24'h9C0000);
      check(status1, 8'h00, "write without latch");
      frame(6'h08, {`SFW_OP_WRITE_EN, 24'h000000});
      check(status1, 8'h02, "latch set");
      frame(6'h10, {`SFW_OP_WRITE_REGS, 24'h9C0000});
      check(status1, 8'h03, "busy");
      repeat (nv + 4) @(negedge core_clk);
      check(status1, 8'h9C, "8-bit write");
      check(cfg, 8'h00, "8-bit leaves config");
      wr(1'b1, 6'h18, 24'hE00600);
      check(status1, 8'h80, "read-only flags");
      check(cfg, 8'h06, "16-bit write");
      wr(1'b1, 6'h20, 24'h800060);
      check(cfg, 8'h04, "one-time bit kept");
      check(status2, 8'h60, "24-bit write");
      wr(1'b1, 6'h14, 24'h000000);
      check(status1, 8'h82, "bad length");
      frame(6'h20, {`SFW_OP_WRITE_REGS, 24'h800400});
      check(status1, 8'h80, "volatile done");
      check(status2, 8'h00, "volatile value");
      for (int k = 0; k < 5; k++) begin
         @(negedge core_clk);
         wp_n = prot_tab[k][16];
         repeat (4) @(negedge core_clk);
         wr(1'b1, 6'h10, {prot_tab[k][15:8], 16'h0000});
         check(status1, prot_tab[k][7:0], "protect");
      end
      frame(6'h08, {`SFW_OP_WRITE_EN, 24'h000000});
      frame(6'h08, {`SFW_OP_WRITE_DIS, 24'h000000});
      check(status1, 8'h00, "latch dropped");
      // prefix sent only while idle and without fail flags
      frame(6'h08, {`SFW_OP_BANK_PREFIX, 24'h000000});
      check({7'h00, bank_open}, 8'h01, "window open");
      frame(6'h18, {`SFW_OP_WRITE_REGS, 24'hFF5500});
      check(bank_addr, 8'h03, "bank low bits");
      check({7'h00, bank_open}, 8'h00, "window closed");
      check(status1, 8'h00, "bank write no latch");
      frame(6'h08, {`SFW_OP_BANK_PREFIX, 24'h000000});
      frame(6'h00, 32'h00000000);
      check({7'h00, bank_open}, 8'h00, "select closes");
      wr(1'b1, 6'h10, 24'h1C0000);
      check(status1, 8'h1C, "normal after close");
      check(bank_addr, 8'h03, "bank kept");
      for (int k = 0; k < 2; k++) begin
         prog_fault = (k == 0);
         erase_fault = (k == 1);
         wr(1'b1, 6'h10, 24'h000000);
         check(status1, (k == 0) ? 8'h5D : 8'h3D, "fault");
         prog_fault = 1'b0;
         erase_fault = 1'b0;
         frame(6'h08, {`SFW_OP_CLEAR_STATUS, 24'h000000});
         check(status1, 8'h1C, "flags cleared");
      end
      finish_test();
   end
endmodule
